// [rtl/nbsp_serial_port.sv]
// Behaviour
// - internal clock: divided rate driven on clock pin
// - internal clock waits until buffer is serviced
// - fastest internal rate 62500 bit/s
// - leading edge shifts on falling clock
// - trailing edge uses rising clock, not transmit
// - length bit selects 4/8-bit, interrupt per unit
// - 8-bit: lower nibble first, then upper nibble
// - mode field picks transmit, receive or both
// - buffer writes ignored unless transmitting mode
// - enable starts; data out lsb first
// - transmit-only load raises empty request; write withdraws it
// - internal clock stops when no new data
// - clearing enable finishes current unit first
// - active flag status bit 3, clears at end
// - both modes: drive leading, sample trailing
// - full unit received moves to buffer, request
// - both modes internal: wait read and write
// - stop bit aborts, clears counter, self-clears
// - forced stop drives output high in transmit-only mode, keeps shifter
// - reset: command one ones, command two zeros
`timescale 1ns/100ps
`include "nbsp_params.svh"

module nbsp_serial_port #(
   parameter int unsigned CORE_HZ = `NBSP_CORE_HZ,
   parameter int unsigned MAX_BPS = `NBSP_MAX_BPS
) (
   input wire logic core_clk, // core clock
   input wire logic sys_rst, // async reset, high
   input wire logic [3:0] reg_addr, // register index
   input wire logic [3:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [3:0] reg_rdata, // read data, cycle after strobe
   input wire logic sck_in, // serial clock pin level
   output logic sck_out, // serial clock drive value
   output logic sck_oe, // serial clock drive enable
   input wire logic si_in, // serial data in pin
   output logic so_out, // serial data out value
   output logic so_oe, // serial data out enable
   output logic serial_unit_interrupt, // buffer service request
   output nbsp_pkg::nbsp_phase_t xfer_phase // transfer phase
);
   import nbsp_pkg::*;

   // ****************************************
   // constants
   // ****************************************
   // fastest rate divider
   localparam int unsigned HALF_FAST = CORE_HZ / (2 * MAX_BPS);
   localparam int unsigned HALF_SLOW = HALF_FAST * `NBSP_SLOW_DIV;
   localparam int CW = $clog2(HALF_SLOW + 1);
   localparam logic [CW-1:0] RLD_FAST = CW'(HALF_FAST - 1);
   localparam logic [CW-1:0] RLD_SLOW = CW'(HALF_SLOW - 1);
   localparam logic [3:0] C1_RST = `NBSP_CMD1_RST;
   localparam logic [3:0] C2_RST = `NBSP_CMD2_RST;

   // ****************************************
   // state
   // ****************************************
   logic [2:0] cmd1_r;
   logic [3:0] cmd2_r;
   logic [7:0] buf_r;
   logic [7:0] tx_sh_r;
   logic [7:0] rx_sh_r;
   logic [2:0] bit_cnt_r;
   logic [CW-1:0] half_cnt_r;
   logic sck_r;
   logic so_r;
   logic so_oe_r;
   logic sck_oe_r;
   logic req_r;
   logic txf_r;
   logic rxf_r;
   logic wr_hi_r;
   logic rd_hi_r;
   logic [3:0] rdata_r;
   nbsp_phase_t st_r;
   logic sck_s1_r;
   logic sck_s2_r;
   logic sck_s3_r;
   logic si_s1_r;
   logic si_s2_r;

   // ****************************************
   // decode
   // ****************************************
   wire logic wr_c1 = reg_wr && reg_addr == `NBSP_OFS_CMD1;
   wire logic wr_c2 = reg_wr && reg_addr == `NBSP_OFS_CMD2;
   wire logic wr_bf = reg_wr && reg_addr == `NBSP_OFS_BUF;
   wire logic rd_bf = reg_rd && reg_addr == `NBSP_OFS_BUF;

   wire nbsp_mode_t mode = nbsp_mode_t'(cmd2_r[`NBSP_CMD2_MODE_HI:`NBSP_CMD2_MODE_LO]);
   wire logic ext = cmd2_r[`NBSP_CMD2_EXT];
   wire logic en = cmd2_r[`NBSP_CMD2_EN];
   wire logic unit8 = cmd1_r[`NBSP_CMD1_UNIT8];
   wire logic lead = cmd1_r[`NBSP_CMD1_LEAD];
   wire logic fast = cmd1_r[`NBSP_CMD1_FAST];
   wire logic tx_mode = mode == NBSP_MODE_TX || mode == NBSP_MODE_TXRX;
   wire logic rx_mode = mode == NBSP_MODE_RX || mode == NBSP_MODE_TXRX;
   wire logic active = st_r != NBSP_PH_IDLE;

   wire logic force_stop = wr_c1 && reg_wdata[`NBSP_CMD1_STOP];
   wire logic start = wr_c2 && reg_wdata[`NBSP_CMD2_EN] && !active;

   wire logic last_bit = bit_cnt_r == (unit8 ? 3'h7 : 3'h3);

   // buffer serviced in each selected direction before next unit
   wire logic ready = (!tx_mode || txf_r) && (!rx_mode || !rxf_r);

   // ****************************************
   // clock edges
   // ****************************************
   wire logic tick = half_cnt_r == '0;
   wire logic ext_fall = sck_s3_r && !sck_s2_r;
   wire logic ext_rise = !sck_s3_r && sck_s2_r;
   // no falling edge until buffer is ready
   wire logic int_go = st_r == NBSP_PH_SHIFT || (st_r == NBSP_PH_WAIT && en && ready);
   wire logic int_fall = tick && sck_r && int_go;
   wire logic int_rise = tick && !sck_r;
   wire logic fall = active && !force_stop && (ext ? ext_fall : int_fall);
   wire logic rise = active && !force_stop && (ext ? ext_rise : int_rise);
   wire logic first = st_r == NBSP_PH_WAIT;

   // leading edge sampling only in receive mode
   wire logic rx_lead = mode == NBSP_MODE_RX && lead;
   wire logic step = rx_lead ? fall : (rise && st_r == NBSP_PH_SHIFT);
   wire logic done = step && last_bit;
   wire logic [7:0] rx_nxt = {si_s2_r, rx_sh_r[7:1]};

   // ****************************************
   // buffer access
   // ****************************************
   // writes ignored outside transmitting modes
   wire logic wr_ok = wr_bf && tx_mode;
   wire logic wr_last = wr_ok && (!unit8 || wr_hi_r);
   wire logic rd_last = rd_bf && (!unit8 || rd_hi_r);
   wire logic [3:0] rd_nib = (unit8 && rd_hi_r) ? buf_r[7:4] : buf_r[3:0];
   // request on load or on full unit
   wire logic set_req = (fall && first && mode == NBSP_MODE_TX) || (done && rx_mode);
   wire logic clr_req = (wr_ok && tx_mode) || (rd_last && mode == NBSP_MODE_RX);
   wire logic ptr_rst = wr_c1 || wr_c2 || set_req;

   wire logic [3:0] stat_val = {active, req_r, txf_r, rxf_r};
   wire logic [3:0] rd_val =
      (reg_addr == `NBSP_OFS_CMD1) ? {1'b0, cmd1_r} :
      (reg_addr == `NBSP_OFS_CMD2) ? cmd2_r :
      (reg_addr == `NBSP_OFS_BUF) ? rd_nib :
      (reg_addr == `NBSP_OFS_STAT) ? stat_val : 4'h0;

   // ****************************************
   // synchronisers
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
         sck_s3_r <= 1'b1;
         si_s1_r <= 1'b1;
         si_s2_r <= 1'b1;
      end else begin
         sck_s1_r <= sck_in;
         sck_s2_r <= sck_s1_r;
         sck_s3_r <= sck_s2_r;
         si_s1_r <= si_in;
         si_s2_r <= si_s1_r;
      end
   end

   // ****************************************
   // command registers
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cmd1_r <= C1_RST[2:0];
         cmd2_r <= C2_RST;
      end else begin
         // stop bit is not stored, so it reads back as zero
         if (wr_c1) begin
            cmd1_r <= reg_wdata[2:0];
         end
         // stop clears enable, other bits kept
         if (force_stop) begin
            cmd2_r[`NBSP_CMD2_EN] <= 1'b0;
         end else if (wr_c2) begin
            cmd2_r <= reg_wdata;
         end
      end
   end

   // ****************************************
   // sequencing
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= NBSP_PH_IDLE;
         bit_cnt_r <= 3'h0;
      end else if (force_stop) begin
         st_r <= NBSP_PH_IDLE;
         bit_cnt_r <= 3'h0;
      end else if (start) begin
         st_r <= NBSP_PH_WAIT;
      end else if (done) begin
         bit_cnt_r <= 3'h0;
         st_r <= en ? NBSP_PH_WAIT : NBSP_PH_IDLE;
      end else begin
         if (step) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
         end
         // external edge starts a unit even if unserviced
         if (fall) begin
            st_r <= NBSP_PH_SHIFT;
         end else if (first && !en) begin
            st_r <= NBSP_PH_IDLE;
         end
      end
   end

   // ****************************************
   // internal clock generator
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         half_cnt_r <= '0;
         sck_r <= 1'b1;
      end else if (!active || ext) begin
         half_cnt_r <= '0;
         sck_r <= 1'b1;
      end else if (tick) begin
         if (int_fall || int_rise) begin
            half_cnt_r <= fast ? RLD_FAST : RLD_SLOW;
            sck_r <= !sck_r;
         end
      end else begin
         half_cnt_r <= half_cnt_r - CW'(1);
      end
   end

   // ****************************************
   // shift registers and data out
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_sh_r <= 8'h00;
         rx_sh_r <= 8'h00;
         so_r <= 1'b1;
      end else begin
         if (force_stop) begin
            if (mode == NBSP_MODE_TX) begin
               so_r <= 1'b1;
            end
         end else if (start && tx_mode) begin
            so_r <= tx_sh_r[0];
         end else if (fall && tx_mode) begin
            // lsb first on the leading edge
            if (first) begin
               tx_sh_r <= buf_r;
               so_r <= buf_r[0];
            end else begin
               tx_sh_r <= {1'b0, tx_sh_r[7:1]};
               so_r <= tx_sh_r[1];
            end
         end
         if (step && rx_mode) begin
            rx_sh_r <= rx_nxt;
         end
      end
   end

   // ****************************************
   // shared buffer and flags
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         buf_r <= 8'h00;
         txf_r <= 1'b0;
         rxf_r <= 1'b0;
         req_r <= 1'b0;
         wr_hi_r <= 1'b0;
         rd_hi_r <= 1'b0;
      end else begin
         // received unit overwrites the shared buffer
         if (done && rx_mode) begin
            buf_r <= unit8 ? rx_nxt : {4'h0, rx_nxt[7:4]};
         end else if (wr_ok) begin
            if (unit8 && wr_hi_r) begin
               buf_r[7:4] <= reg_wdata;
            end else begin
               buf_r[3:0] <= reg_wdata;
            end
         end
         // buffer emptied when moved to the shifter
         if (wr_last) begin
            txf_r <= 1'b1;
         end else if (fall && first && tx_mode) begin
            txf_r <= 1'b0;
         end
         if (done && rx_mode) begin
            rxf_r <= 1'b1;
         end else if (rd_last) begin
            rxf_r <= 1'b0;
         end
         if (set_req) begin
            req_r <= 1'b1;
         end else if (clr_req) begin
            req_r <= 1'b0;
         end
         // pointers restart on mode setting or request
         if (ptr_rst) begin
            wr_hi_r <= 1'b0;
            rd_hi_r <= 1'b0;
         end else begin
            if (wr_ok && unit8) begin
               wr_hi_r <= !wr_hi_r;
            end
            if (rd_bf && unit8) begin
               rd_hi_r <= !rd_hi_r;
            end
         end
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 4'h0;
         so_oe_r <= 1'b0;
         sck_oe_r <= 1'b0;
      end else begin
         rdata_r <= reg_rd ? rd_val : 4'h0;
         // receive only leaves the data out pin to the port
         so_oe_r <= tx_mode;
         sck_oe_r <= !ext;
      end
   end

   assign reg_rdata = rdata_r;
   assign sck_out = sck_r;
   assign sck_oe = sck_oe_r;
   assign so_out = so_r;
   assign so_oe = so_oe_r;
   assign serial_unit_interrupt = req_r;
   assign xfer_phase = st_r;

endmodule

// [rtl/nbsp_params.svh]
`ifndef NBSP_PARAMS_SVH
`define NBSP_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define NBSP_OFS_CMD1 4'h0
`define NBSP_OFS_CMD2 4'h1
`define NBSP_OFS_BUF 4'h2
`define NBSP_OFS_STAT 4'h3

// ****************************************
// reset values
// ****************************************
`define NBSP_CMD1_RST 4'hF
`define NBSP_CMD2_RST 4'h0

// ****************************************
// field positions
// ****************************************
`define NBSP_CMD1_LEAD 0
`define NBSP_CMD1_FAST 1
`define NBSP_CMD1_UNIT8 2
`define NBSP_CMD1_STOP 3
`define NBSP_CMD2_EXT 0
`define NBSP_CMD2_MODE_LO 1
`define NBSP_CMD2_MODE_HI 2
`define NBSP_CMD2_EN 3
`define NBSP_STAT_RXF 0
`define NBSP_STAT_TXF 1
`define NBSP_STAT_REQ 2
`define NBSP_STAT_ACTIVE 3

// ****************************************
// timing
// ****************************************
`define NBSP_CORE_HZ 40000000
`define NBSP_MAX_BPS 62500
`define NBSP_SLOW_DIV 4

`endif

// [rtl/nbsp_pkg.sv]
package nbsp_pkg;
   typedef enum logic [1:0] {
      NBSP_MODE_NONE,
      NBSP_MODE_TX,
      NBSP_MODE_RX,
      NBSP_MODE_TXRX
   } nbsp_mode_t;

   typedef enum logic [1:0] {
      NBSP_PH_IDLE,
      NBSP_PH_WAIT,
      NBSP_PH_SHIFT
   } nbsp_phase_t;
endpackage

// [test/nbsp_serial_port_props.sv]
`timescale 1ns/100ps
`include "nbsp_params.svh"
module nbsp_props #(
   parameter int unsigned CORE_HZ = 40000000,
   parameter int unsigned MAX_BPS = 62500
) (
   input wire logic core_clk, // clock
   input wire logic sys_rst, // reset
   input wire logic [3:0] reg_addr, // index
   input wire logic [3:0] reg_wdata, // wdata
   input wire logic reg_wr, // write
   input wire logic reg_rd, // read
   input wire logic [3:0] reg_rdata, // rdata
   input wire logic sck_in, // clock pin
   input wire logic sck_out, // clock drive
   input wire logic sck_oe, // clock enable
   input wire logic si_in, // data in
   input wire logic so_out, // data out
   input wire logic so_oe, // data out enable
   input wire logic serial_unit_interrupt, // request
   input wire nbsp_pkg::nbsp_phase_t xfer_phase // phase
);
   import nbsp_pkg::*;
   localparam int unsigned HALF = CORE_HZ / MAX_BPS / 2;
   logic [15:0] lo_cnt_r;
   logic [3:0] cmd2_r;
   // ****************
   // helper state
   // ****************
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lo_cnt_r <= 16'h0000;
         cmd2_r <= 4'h0;
      end else begin
         lo_cnt_r <= sck_out ? 16'h0000 : lo_cnt_r + 16'h0001;
         if (reg_wr && reg_addr == `NBSP_OFS_CMD2) begin
            cmd2_r <= reg_wdata;
         end
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   AST_SCK_IDLE: assert property (xfer_phase != NBSP_PH_SHIFT
      && $past(xfer_phase) != NBSP_PH_SHIFT |-> sck_out) else $error("clock moved while idle");
   AST_SCK_LOW: assert property ($rose(sck_out) && sck_oe
      |-> 32'(lo_cnt_r) == HALF || 32'(lo_cnt_r) == 4 * HALF) else $error("bad clock low time");
   AST_SO_AT_FALL: assert property (sck_oe && so_oe && xfer_phase == NBSP_PH_SHIFT
      && $changed(so_out) |-> !sck_out) else $error("data out moved off falling edge");
   AST_STOP_IDLE: assert property (reg_wr && reg_addr == `NBSP_OFS_CMD1
      && reg_wdata[3] |-> ##[1:2] xfer_phase == NBSP_PH_IDLE) else $error("stop ignored");
   AST_STOP_SO_HIGH: assert property (reg_wr && reg_addr == `NBSP_OFS_CMD1
      && reg_wdata[3] && so_oe |-> ##[1:2] so_out) else $error("data out not high on stop");
   AST_SO_OE_MODE: assert property (reg_wr && reg_addr == `NBSP_OFS_CMD2
      |=> ##1 so_oe == cmd2_r[1]) else $error("data out enable wrong for mode");
   AST_SCK_OE_SRC: assert property (reg_wr && reg_addr == `NBSP_OFS_CMD2
      |=> ##1 sck_oe == !cmd2_r[0]) else $error("clock enable wrong for source");
   AST_ACTIVE_STAT: assert property (reg_rd && reg_addr == `NBSP_OFS_STAT
      && xfer_phase == NBSP_PH_SHIFT |=> reg_rdata[3]) else $error("active flag low in shift");
   AST_IRQ_CLEAR: assert property (serial_unit_interrupt && reg_wr && so_oe
      && reg_addr == `NBSP_OFS_BUF |-> ##[1:2] !serial_unit_interrupt) else $error("request kept");
endmodule
bind nbsp_serial_port nbsp_props #(.CORE_HZ(CORE_HZ), .MAX_BPS(MAX_BPS)) i_props (
   .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_in(sck_in),
   .sck_out(sck_out), .sck_oe(sck_oe), .si_in(si_in), .so_out(so_out), .so_oe(so_oe),
   .serial_unit_interrupt(serial_unit_interrupt), .xfer_phase(xfer_phase));

// [test/nbsp_peer.sv]
`timescale 1ns/100ps
module nbsp_peer (
   input wire logic sck, // clock pin
   input wire logic so, // device data
   input wire logic so_en, // device drives data
   output logic sck_o, // clock, high when released
   output logic si_o, // data to device
   output logic [15:0] got // captured, lsb first
);
   // released clock line rests high like the port latch
   initial begin
      sck_o = 1'b1;
      si_o = 1'b0;
      got = 16'h0000;
   end
   always @(posedge sck) begin
      if (so_en) begin
         got = {so, got[15:1]};
      end
   end
   task automatic burst(input int n, input logic [7:0] d);
      // keep pin changes away from the core clock edge
      #3;
      for (int i = 0; i < n; i++) begin
         si_o = d[i];
         #100 sck_o = 1'b0;
         #100 sck_o = 1'b1;
      end
      // line released: show the inverse, not a held value
      si_o = ~d[n-1];
   endtask
endmodule

// [test/tb.sv]
`timescale 1ns/100ps
`include "nbsp_params.svh"
module tb;
   import nbsp_pkg::*;
   localparam int unsigned MBPS = 2500000;
   localparam int HALF = 8;
   localparam logic [11:0] ROWS [10] = '{12'h007, 12'h010, 12'h030, 12'h090, 12'h12A,
      12'h030, 12'h10E, 12'h006, 12'h114, 12'h014};
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [3:0] reg_wdata = 4'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] reg_rdata;
   logic sck_out, sck_oe, so_out, so_oe, irq, peer_sck, peer_si;
   logic [15:0] got;
   nbsp_phase_t xfer_phase;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   wire sck_pin = sck_oe ? sck_out : peer_sck;
   nbsp_serial_port #(.CORE_HZ(40000000), .MAX_BPS(MBPS)) i_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sck_in(sck_pin),
      .sck_out(sck_out), .sck_oe(sck_oe), .si_in(peer_si), .so_out(so_out), .so_oe(so_oe),
      .serial_unit_interrupt(irq), .xfer_phase(xfer_phase));
   nbsp_peer i_peer (.sck(sck_pin), .so(so_out), .so_en(so_oe), .sck_o(peer_sck),
      .si_o(peer_si), .got(got));
   initial begin
      forever #12.5 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdc(input logic [3:0] a, input logic [3:0] e, input logic [3:0] m);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      // read data stand only in this cycle, so look once they have settled
      #1;
      chk(16'(reg_rdata & m), 16'(e));
      @(posedge core_clk);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      @(posedge core_clk);
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
      chk(16'(irq), 16'h0001);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         end_of_test();
      end
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      repeat (20) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      foreach (ROWS[i]) begin
         if (ROWS[i][8]) begin
            wr(ROWS[i][7:4], ROWS[i][3:0]);
         end else begin
            rdc(ROWS[i][7:4], ROWS[i][3:0], 4'hF);
         end
      end
      // internal clock transmit, two bytes then starved
      wr(`NBSP_OFS_CMD1, 4'h7);
      wr(`NBSP_OFS_CMD2, 4'h2);
      wr(`NBSP_OFS_BUF, 4'h5);
      wr(`NBSP_OFS_BUF, 4'hA);
      rdc(`NBSP_OFS_STAT, 4'h2, 4'h2);
      wr(`NBSP_OFS_CMD2, 4'hA);
      wait_irq();
      rdc(`NBSP_OFS_STAT, 4'hC, 4'hC);
      wr(`NBSP_OFS_BUF, 4'hC);
      wr(`NBSP_OFS_BUF, 4'h3);
      wait_irq();
      repeat (20 * HALF) @(posedge core_clk);
      chk(got, 16'h3CA5);
      chk(16'(xfer_phase), 16'(NBSP_PH_WAIT));
      chk(16'(sck_out), 16'h0001);
      wr(`NBSP_OFS_CMD2, 4'h2);
      repeat (4) @(posedge core_clk);
      rdc(`NBSP_OFS_STAT, 4'h0, 4'h8);
      // external clock receive, 4-bit unit
      wr(`NBSP_OFS_CMD1, 4'h3);
      wr(`NBSP_OFS_CMD2, 4'h5);
      wr(`NBSP_OFS_CMD2, 4'hD);
      i_peer.burst(4, 8'h09);
      wait_irq();
      chk(16'(so_oe), 16'h0000);
      // received data read before any new write
      rdc(`NBSP_OFS_BUF, 4'h9, 4'hF);
      wr(`NBSP_OFS_CMD1, 4'hB);
      // external clock transmit, forced stop mid-unit
      wr(`NBSP_OFS_CMD1, 4'h5);
      // buffer filled before the first external shift
      wr(`NBSP_OFS_CMD2, 4'h3);
      wr(`NBSP_OFS_BUF, 4'h0);
      wr(`NBSP_OFS_BUF, 4'h0);
      wr(`NBSP_OFS_CMD2, 4'hB);
      // unit cut short by software instead of a late disable
      i_peer.burst(3, 8'h00);
      @(posedge core_clk);
      wr(`NBSP_OFS_CMD1, 4'hD);
      chk(16'(so_out), 16'h0001);
      chk(16'(xfer_phase), 16'(NBSP_PH_IDLE));
      rdc(`NBSP_OFS_CMD2, 4'h3, 4'hF);
      rdc(`NBSP_OFS_CMD1, 4'h5, 4'hF);
      end_of_test();
   end
endmodule
